// [logic/focpb_map.vh]
// constants of the motor tuning parameter bank: offsets, fields, resets
// assumes the including file runs on one system clock
//
// Contract
// [R1] brake align kp exponent is signed 4-bit
// [R2] brake align ki exponent is signed 6-bit
// [R3] reverse speed threshold is field plus one
// [R4] reverse d reference is field plus one
// [R5] tach gain scaled by two over pole-pairs; code leaves it unscaled at one pole pair
// [R6] pole-pair count is field plus one
// [R7] single bit enables no-motor start detection
// [R8] 12-bit unsigned stator inductance constant
// [R9] inductance fractional scaling is five plus field
// [R10] ramp-up d reference is field plus one
// [R11] drive d reference is minus field
// [R12] d-axis kp exponent is signed 5-bit
// [R13] d-axis ki exponent is signed 6-bit
// [R14] q-axis kp exponent is signed 5-bit
// [R15] exponents are two's complement values
`ifndef FOCPB_MAP_VH
`define FOCPB_MAP_VH

// ----------------------------------------------------------------
// register offsets (i2c register address space)
// ----------------------------------------------------------------
`define FOCPB_OFS_LS       12'h405
`define FOCPB_OFS_FGP_SH   12'h464
`define FOCPB_OFS_DREF_SH  12'h465
`define FOCPB_OFS_PIG_SH   12'h466
`define FOCPB_OFS_FGP_NV   12'h4C4
`define FOCPB_OFS_DREF_NV  12'h4C5
`define FOCPB_OFS_PIG_NV   12'h4C6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FOCPB_RST_W32      32'h00000000
`define FOCPB_RST_W16      16'h0000

// ----------------------------------------------------------------
// fields of the tach gain / pole pair word
// ----------------------------------------------------------------
`define FOCPB_BAP_MSB      3
`define FOCPB_BAP_LSB      0
`define FOCPB_BAI_MSB      9
`define FOCPB_BAI_LSB      4
`define FOCPB_RST_MSB      12
`define FOCPB_RST_LSB      10
`define FOCPB_RDR_MSB      17
`define FOCPB_RDR_LSB      13
`define FOCPB_TG_MSB       27
`define FOCPB_TG_LSB       18
`define FOCPB_PP_MSB       30
`define FOCPB_PP_LSB       28
`define FOCPB_NMD_BIT      31

// ----------------------------------------------------------------
// fields of the stator inductance word
// ----------------------------------------------------------------
`define FOCPB_LS_MSB       11
`define FOCPB_LS_LSB       0
`define FOCPB_LSF_MSB      15
`define FOCPB_LSF_LSB      12
`define FOCPB_LSF_BASE     5'h05

// ----------------------------------------------------------------
// fields of the d current reference word
// ----------------------------------------------------------------
`define FOCPB_RUP_MSB      25
`define FOCPB_RUP_LSB      21
`define FOCPB_DRV_MSB      29
`define FOCPB_DRV_LSB      26

// ----------------------------------------------------------------
// fields of the current pi gain word
// ----------------------------------------------------------------
`define FOCPB_DKP_MSB      4
`define FOCPB_DKP_LSB      0
`define FOCPB_DKI_MSB      10
`define FOCPB_DKI_LSB      5
`define FOCPB_QKP_MSB      15
`define FOCPB_QKP_LSB      11

`endif

// [logic/focpb_sync.v]
// two-stage synchroniser for one pin level
// assumes the pin is asynchronous to clk_sys; resets to a chosen idle level
`timescale 1ns/100ps
`default_nettype none

module focpb_sync #(
  parameter IDLE = 1'b1
)(
  input  wire clk_sys,
  input  wire rst_b,
  input  wire pin_in,
  output wire pin_sync
);

  reg meta_r;
  reg sync_r;

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      meta_r <= IDLE;
      sync_r <= IDLE;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  assign pin_sync = sync_r;

endmodule // focpb_sync

`default_nettype wire

// [logic/focpb_bank.v]
// tuning parameter bank with its i2c target port and decoded outputs
// assumes scl/sda pins arrive asynchronously; no clock stretching is done
`timescale 1ns/100ps
`default_nettype none
`include "focpb_map.vh"

module focpb_bank #(
  // target address on the two-wire bus; value is arbitrary
  parameter [6:0] DEV_ADDR = 7'h55
)(
  input  wire               clk_sys,
  input  wire               rst_b,
  input  wire               scl_in,
  input  wire               sda_in,
  output reg                sda_out,
  output reg                sda_oe,
  output reg  signed [3:0]  brake_align_prop_exp,
  output reg  signed [5:0]  brake_align_int_exp,
  output reg         [3:0]  reverse_openloop_speed_thresh,
  output reg         [5:0]  reverse_d_current_ref,
  output reg         [11:0] tach_gain_num,
  output reg         [3:0]  tach_gain_den,
  output reg         [3:0]  pole_pair_count,
  output reg                no_motor_detect_en,
  output reg         [11:0] stator_inductance,
  output reg  signed [4:0]  stator_inductance_frac,
  output reg         [5:0]  rampup_d_current_ref,
  output reg  signed [4:0]  drive_d_current_ref,
  output reg  signed [4:0]  d_axis_prop_exp,
  output reg  signed [5:0]  d_axis_int_exp,
  output reg  signed [4:0]  q_axis_prop_exp
);

  // ----------------------------------------------------------------
  // protocol states
  // ----------------------------------------------------------------
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_AACK = 7'h04;
  localparam [6:0] ST_RX   = 7'h08;
  localparam [6:0] ST_RACK = 7'h10;
  localparam [6:0] ST_TX   = 7'h20;
  localparam [6:0] ST_TACK = 7'h40;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg  [15:0] ls_r;
  reg  [31:0] fgp_sh_r;
  reg  [31:0] dref_sh_r;
  reg  [31:0] pig_sh_r;
  reg  [31:0] fgp_nv_r;
  reg  [31:0] dref_nv_r;
  reg  [31:0] pig_nv_r;

  // ----------------------------------------------------------------
  // serial engine state
  // ----------------------------------------------------------------
  reg  [6:0]  state_r;
  reg  [3:0]  cnt_r;
  reg  [7:0]  shift_r;
  reg         rw_r;
  reg         ack_r;
  reg  [2:0]  idx_r;
  reg  [1:0]  tx_idx_r;
  reg  [11:0] addr_r;
  reg  [23:0] wdata_r;
  reg  [31:0] rdata_r;
  reg         scl_d_r;
  reg         sda_d_r;
  reg  [31:0] rd_word;
  reg         wr_en;
  reg  [31:0] wr_word;

  wire        scl_s;
  wire        sda_s;
  wire        scl_rise;
  wire        scl_fall;
  wire        bus_start;
  wire        bus_stop;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  focpb_sync #(.IDLE(1'b1)) u_sync_scl (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .pin_in   (scl_in),
    .pin_sync (scl_s)
  );

  focpb_sync #(.IDLE(1'b1)) u_sync_sda (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .pin_in   (sda_in),
    .pin_sync (sda_s)
  );

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  // unmapped addresses read as zero
  always @* begin
    rd_word = 32'h00000000;
    if (addr_r == `FOCPB_OFS_LS) begin
      rd_word = {16'h0000, ls_r};
    end else if (addr_r == `FOCPB_OFS_FGP_SH) begin
      rd_word = fgp_sh_r;
    end else if (addr_r == `FOCPB_OFS_DREF_SH) begin
      rd_word = dref_sh_r;
    end else if (addr_r == `FOCPB_OFS_PIG_SH) begin
      rd_word = pig_sh_r;
    end else if (addr_r == `FOCPB_OFS_FGP_NV) begin
      rd_word = fgp_nv_r;
    end else if (addr_r == `FOCPB_OFS_DREF_NV) begin
      rd_word = dref_nv_r;
    end else if (addr_r == `FOCPB_OFS_PIG_NV) begin
      rd_word = pig_nv_r;
    end
  end

  // fourth data byte completes a word write
  always @* begin
    wr_en   = (state_r == ST_RX) & scl_fall & (cnt_r == 4'h8)
              & (idx_r == 3'h5);
    wr_word = {wdata_r, shift_r};
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // nvm image is storage only; no programming cycle is modelled
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      ls_r      <= `FOCPB_RST_W16;
      fgp_sh_r  <= `FOCPB_RST_W32;
      dref_sh_r <= `FOCPB_RST_W32;
      pig_sh_r  <= `FOCPB_RST_W32;
      fgp_nv_r  <= `FOCPB_RST_W32;
      dref_nv_r <= `FOCPB_RST_W32;
      pig_nv_r  <= `FOCPB_RST_W32;
    end else if (wr_en) begin
      if (addr_r == `FOCPB_OFS_LS) begin
        ls_r <= wr_word[15:0];
      end else if (addr_r == `FOCPB_OFS_FGP_SH) begin
        fgp_sh_r <= wr_word;
      end else if (addr_r == `FOCPB_OFS_DREF_SH) begin
        dref_sh_r <= wr_word;
      end else if (addr_r == `FOCPB_OFS_PIG_SH) begin
        pig_sh_r <= wr_word;
      end else if (addr_r == `FOCPB_OFS_FGP_NV) begin
        fgp_nv_r <= wr_word;
      end else if (addr_r == `FOCPB_OFS_DREF_NV) begin
        dref_nv_r <= wr_word;
      end else if (addr_r == `FOCPB_OFS_PIG_NV) begin
        pig_nv_r <= wr_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------
  // start and stop win over any bit activity, even mid-byte
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      state_r  <= ST_IDLE;
      cnt_r    <= 4'h0;
      shift_r  <= 8'h00;
      rw_r     <= 1'b0;
      ack_r    <= 1'b0;
      idx_r    <= 3'h0;
      tx_idx_r <= 2'h0;
      addr_r   <= 12'h000;
      wdata_r  <= 24'h000000;
      rdata_r  <= 32'h00000000;
    end else if (bus_start) begin
      state_r <= ST_ADDR;
      cnt_r   <= 4'h0;
      idx_r   <= 3'h0;
    end else if (bus_stop) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_ADDR, ST_RX: begin
          if (scl_rise && cnt_r != 4'h8) begin
            shift_r <= {shift_r[6:0], sda_s};
            cnt_r   <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == 4'h8) begin
            cnt_r <= 4'h0;
            if (state_r == ST_ADDR) begin
              rw_r    <= shift_r[0];
              state_r <= (shift_r[7:1] == DEV_ADDR) ? ST_AACK : ST_IDLE;
            end else begin
              state_r <= ST_RACK;
              case (idx_r)
                3'h0: addr_r[11:8] <= shift_r[3:0];
                3'h1: addr_r[7:0]  <= shift_r;
                3'h5: addr_r       <= addr_r + 12'h001;
                default: wdata_r   <= {wdata_r[15:0], shift_r};
              endcase
              idx_r <= (idx_r == 3'h5) ? 3'h2 : idx_r + 3'h1;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              state_r  <= ST_TX;
              rdata_r  <= rd_word;
              shift_r  <= rd_word[31:24];
              tx_idx_r <= 2'h0;
            end else begin
              state_r <= ST_RX;
            end
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            state_r <= ST_RX;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            shift_r <= {shift_r[6:0], 1'b0};
            if (cnt_r == 4'h7) begin
              cnt_r   <= 4'h0;
              state_r <= ST_TACK;
            end else begin
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            ack_r <= ~sda_s;
          end else if (scl_fall) begin
            if (!ack_r) begin
              state_r <= ST_IDLE;
            end else begin
              state_r  <= ST_TX;
              tx_idx_r <= tx_idx_r + 2'h1;
              // address advances as the last byte of a word starts
              if (tx_idx_r == 2'h3) begin
                rdata_r <= rd_word;
                shift_r <= rd_word[31:24];
              end else if (tx_idx_r == 2'h0) begin
                shift_r <= rdata_r[23:16];
              end else if (tx_idx_r == 2'h1) begin
                shift_r <= rdata_r[15:8];
              end else begin
                shift_r <= rdata_r[7:0];
                addr_r  <= addr_r + 12'h001;
              end
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // open-drain data pin
  // ----------------------------------------------------------------
  // output level never changes; only the enable pulls the line low
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe  <= (state_r == ST_AACK) | (state_r == ST_RACK)
                 | ((state_r == ST_TX) & ~shift_r[7]);
    end
  end

  // ----------------------------------------------------------------
  // decoded controller values, taken from the shadow copies
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      brake_align_prop_exp          <= 4'h0;
      brake_align_int_exp           <= 6'h00;
      reverse_openloop_speed_thresh <= 4'h0;
      reverse_d_current_ref         <= 6'h00;
      tach_gain_num                 <= 12'h000;
      tach_gain_den                 <= 4'h0;
      pole_pair_count               <= 4'h0;
      no_motor_detect_en            <= 1'b0;
      stator_inductance             <= 12'h000;
      stator_inductance_frac        <= 5'h00;
      rampup_d_current_ref          <= 6'h00;
      drive_d_current_ref           <= 5'h00;
      d_axis_prop_exp               <= 5'h00;
      d_axis_int_exp                <= 6'h00;
      q_axis_prop_exp               <= 5'h00;
    end else begin
      // [R1] [R15] signed kp exponent
      brake_align_prop_exp <= fgp_sh_r[`FOCPB_BAP_MSB:`FOCPB_BAP_LSB];
      // [R2] [R15] signed ki exponent
      brake_align_int_exp <= fgp_sh_r[`FOCPB_BAI_MSB:`FOCPB_BAI_LSB];
      // [R3] threshold in 0.390625% steps
      reverse_openloop_speed_thresh <=
        {1'b0, fgp_sh_r[`FOCPB_RST_MSB:`FOCPB_RST_LSB]} + 4'h1;
      // [R4] reference in 3.125% steps
      reverse_d_current_ref <=
        {1'b0, fgp_sh_r[`FOCPB_RDR_MSB:`FOCPB_RDR_LSB]} + 6'h01;
      // [R5] gain is num/den in 1/256 units; doubling avoids a divider
      if (fgp_sh_r[`FOCPB_PP_MSB:`FOCPB_PP_LSB] == 3'h0) begin
        tach_gain_num <=
          {1'b0, {1'b0, fgp_sh_r[`FOCPB_TG_MSB:`FOCPB_TG_LSB]} + 11'h001};
        tach_gain_den <= 4'h1;
      end else begin
        tach_gain_num <=
          {{1'b0, fgp_sh_r[`FOCPB_TG_MSB:`FOCPB_TG_LSB]} + 11'h001, 1'b0};
        tach_gain_den <=
          {1'b0, fgp_sh_r[`FOCPB_PP_MSB:`FOCPB_PP_LSB]} + 4'h1;
      end
      // [R6] pole-pair count
      pole_pair_count <=
        {1'b0, fgp_sh_r[`FOCPB_PP_MSB:`FOCPB_PP_LSB]} + 4'h1;
      // [R7] detection enable bit
      no_motor_detect_en <= fgp_sh_r[`FOCPB_NMD_BIT];
      // [R8] unsigned inductance constant
      stator_inductance <= ls_r[`FOCPB_LS_MSB:`FOCPB_LS_LSB];
      // [R9] [R15] five plus signed field
      stator_inductance_frac <= `FOCPB_LSF_BASE
        + {ls_r[`FOCPB_LSF_MSB], ls_r[`FOCPB_LSF_MSB:`FOCPB_LSF_LSB]};
      // [R10] reference in 3.125% steps
      rampup_d_current_ref <=
        {1'b0, dref_sh_r[`FOCPB_RUP_MSB:`FOCPB_RUP_LSB]} + 6'h01;
      // [R11] negated, 1.5625% steps
      drive_d_current_ref <=
        5'h00 - {1'b0, dref_sh_r[`FOCPB_DRV_MSB:`FOCPB_DRV_LSB]};
      // [R12] [R15] d-axis kp exponent
      d_axis_prop_exp <= pig_sh_r[`FOCPB_DKP_MSB:`FOCPB_DKP_LSB];
      // [R13] [R15] d-axis ki exponent
      d_axis_int_exp <= pig_sh_r[`FOCPB_DKI_MSB:`FOCPB_DKI_LSB];
      // [R14] [R15] q-axis kp exponent
      q_axis_prop_exp <= pig_sh_r[`FOCPB_QKP_MSB:`FOCPB_QKP_LSB];
    end
  end

endmodule // focpb_bank

`default_nettype wire

// [dv/focpb_bank_assertions.sv]
// port checks for the tuning parameter bank, bound into every instance
// assumes one clock, clk_sys, and synchronous active-low rst_b
`timescale 1ns/100ps
`default_nettype none
module focpb_bank_chk (
  input wire logic              clk_sys,
  input wire logic              rst_b,
  input wire logic              scl_in,
  input wire logic              sda_out,
  input wire logic              sda_oe,
  input wire logic        [3:0] reverse_openloop_speed_thresh,
  input wire logic        [5:0] reverse_d_current_ref,
  input wire logic       [11:0] tach_gain_num,
  input wire logic        [3:0] tach_gain_den,
  input wire logic        [3:0] pole_pair_count,
  input wire logic              no_motor_detect_en,
  input wire logic       [11:0] stator_inductance,
  input wire logic signed [4:0] stator_inductance_frac,
  input wire logic        [5:0] rampup_d_current_ref,
  input wire logic signed [4:0] drive_d_current_ref
);
  logic [2:0] hist_r;
  wire logic  live;

  // decoded outputs settle one edge after release, so wait three
  always @(posedge clk_sys) hist_r <= {hist_r[1:0], rst_b};
  assign live = rst_b && (hist_r == 3'h7);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!live);

  chk_pole_range: assert property
    (pole_pair_count inside {[4'h1:4'h8]})
    else $error("pole pair count out of range");
  chk_tach_den: assert property (tach_gain_den ==
    ((pole_pair_count == 4'h1) ? 4'h1 : pole_pair_count))
    else $error("tach gain divisor does not follow pole pairs");
  chk_tach_num: assert property ((pole_pair_count == 4'h1) ?
    tach_gain_num inside {[12'h001:12'h400]} :
    (!tach_gain_num[0] && tach_gain_num inside {[12'h002:12'h800]}))
    else $error("tach gain numerator inconsistent");
  chk_thresh_range: assert property
    (reverse_openloop_speed_thresh inside {[4'h1:4'h8]})
    else $error("reverse speed threshold out of range");
  chk_rev_ref: assert property
    (reverse_d_current_ref inside {[6'h01:6'h20]})
    else $error("reverse d reference out of range");
  chk_rup_ref: assert property
    (rampup_d_current_ref inside {[6'h01:6'h20]})
    else $error("ramp-up d reference out of range");
  chk_drive_sign: assert property ((drive_d_current_ref == 5'sd0) ||
    (drive_d_current_ref[4] && drive_d_current_ref != 5'h10))
    else $error("drive d reference not negative");
  chk_frac_range: assert property (stator_inductance_frac >= -5'sd3 &&
    stator_inductance_frac <= 5'sd12)
    else $error("inductance scaling out of range");
  chk_drain_low: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("data pin driven high");
  chk_oe_scl_low: assert property (($rose(sda_oe) || $fell(sda_oe)) |->
    !scl_in)
    else $error("data pin changed while clock high");
  // a stored word may only land while the bus clock is low
  chk_cfg_hold: assert property (scl_in [*5] |->
    $stable(no_motor_detect_en) && $stable(pole_pair_count) &&
    $stable(stator_inductance) && $stable(drive_d_current_ref))
    else $error("configuration changed while clock high");

  cover property ($rose(no_motor_detect_en));
  cover property (pole_pair_count == 4'h8);
  cover property ($rose(sda_oe));
  cover property (drive_d_current_ref == -5'sd15);
endmodule // focpb_bank_chk

bind focpb_bank focpb_bank_chk u_chk (
  .clk_sys, .rst_b, .scl_in, .sda_out, .sda_oe,
  .reverse_openloop_speed_thresh, .reverse_d_current_ref, .tach_gain_num,
  .tach_gain_den, .pole_pair_count, .no_motor_detect_en,
  .stator_inductance, .stator_inductance_frac, .rampup_d_current_ref,
  .drive_d_current_ref
);
`default_nettype wire

// [dv/focpb_host.sv]
// two-wire host model that programs and reads the tuning bank
// assumes the bench resolves sda with a pull-up and feeds it back
`timescale 1ns/100ps
`default_nettype none
module focpb_host #(
  parameter logic [6:0] DEV = 7'h55
)(
  input  wire logic clk_sys,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic dly(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // 12-cycle halves stay clear of the 8-cycle minimum phase
  task automatic bit_io(input logic b, output logic r);
    dly(8);
    sda_low <= !b;
    dly(4);
    scl <= 1'b1;
    dly(6);
    r = sda;
    dly(6);
    scl <= 1'b0;
  endtask

  task automatic start_c();
    dly(8);
    sda_low <= 1'b0;
    dly(4);
    scl <= 1'b1;
    dly(12);
    sda_low <= 1'b1;
    dly(12);
    scl <= 1'b0;
  endtask

  task automatic stop_c();
    dly(8);
    sda_low <= 1'b1;
    dly(4);
    scl <= 1'b1;
    dly(12);
    sda_low <= 1'b0;
    dly(12);
  endtask

  task automatic byte_io(input logic [7:0] tx, input logic ab,
                         output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ab, ack);
  endtask

  task automatic addr_ph(input logic [6:0] dev, input logic [11:0] ra,
                         output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start_c();
    byte_io({dev, 1'b0}, 1'b1, rx, a0);
    byte_io({4'h0, ra[11:8]}, 1'b1, rx, a1);
    byte_io(ra[7:0], 1'b1, rx, a2);
    ok = !(a0 | a1 | a2);
  endtask

  // nw words back to back, taken from the low end of d
  task automatic wr32(input logic [6:0] dev, input logic [11:0] ra,
                      input logic [63:0] d, input int nw, output logic ok);
    logic [7:0] rx;
    logic a;
    addr_ph(dev, ra, ok);
    for (int i = 4 * nw - 1; i >= 0; i--) begin
      byte_io(d[i*8 +: 8], 1'b1, rx, a);
      ok = ok & !a;
    end
    stop_c();
  endtask

  // last byte is refused by the host so the target lets go of the line
  task automatic rd32(input logic [11:0] ra, input int nw,
                      output logic [63:0] d);
    logic [7:0] rx;
    logic ok, a;
    d = 64'h0;
    addr_ph(DEV, ra, ok);
    start_c();
    byte_io({DEV, 1'b1}, 1'b1, rx, a);
    for (int i = 4*nw-1; i >= 0; i--) byte_io(8'hFF, i == 0, d[i*8 +: 8], a);
    stop_c();
  endtask
endmodule // focpb_host
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench: programs the bank over two-wire, checks fields
// assumes focpb_host as the bus host and a pull-up on the data line
`timescale 1ns/100ps
`default_nettype none
`include "focpb_map.vh"
module tb_top;
  localparam logic [6:0] DEV = 7'h55;
  logic clk_sys, rst_b, scl, sda_low;
  wire logic sda_w, sda_out, sda_oe, no_motor_detect_en;
  wire logic signed [3:0] brake_align_prop_exp;
  wire logic signed [5:0] brake_align_int_exp, d_axis_int_exp;
  wire logic [3:0] reverse_openloop_speed_thresh, tach_gain_den;
  wire logic [3:0] pole_pair_count;
  wire logic [5:0] reverse_d_current_ref, rampup_d_current_ref;
  wire logic [11:0] tach_gain_num, stator_inductance;
  wire logic signed [4:0] stator_inductance_frac, drive_d_current_ref;
  wire logic signed [4:0] d_axis_prop_exp, q_axis_prop_exp;
  int fail_count = 0;
  int total_checks = 0;
  logic [31:0] mem_m [logic [11:0]];
  logic [11:0] ofs [7] = '{`FOCPB_OFS_LS, `FOCPB_OFS_FGP_SH,
    `FOCPB_OFS_DREF_SH, `FOCPB_OFS_PIG_SH, `FOCPB_OFS_FGP_NV,
    `FOCPB_OFS_DREF_NV, `FOCPB_OFS_PIG_NV};

  assign sda_w = !(sda_low || (sda_oe && !sda_out));

  focpb_host #(.DEV(DEV)) u_focpb_host (
    .clk_sys, .sda(sda_w), .scl, .sda_low);
  focpb_bank #(.DEV_ADDR(DEV)) u_focpb_bank (
    .clk_sys, .rst_b, .scl_in(scl), .sda_in(sda_w), .sda_out, .sda_oe,
    .brake_align_prop_exp, .brake_align_int_exp,
    .reverse_openloop_speed_thresh, .reverse_d_current_ref,
    .tach_gain_num, .tach_gain_den, .pole_pair_count, .no_motor_detect_en,
    .stator_inductance, .stator_inductance_frac, .rampup_d_current_ref,
    .drive_d_current_ref, .d_axis_prop_exp, .d_axis_int_exp,
    .q_axis_prop_exp);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk_outs();
    logic [31:0] f, l, r, g;
    logic [11:0] n1;
    f = mem_m[`FOCPB_OFS_FGP_SH];
    l = mem_m[`FOCPB_OFS_LS];
    r = mem_m[`FOCPB_OFS_DREF_SH];
    g = mem_m[`FOCPB_OFS_PIG_SH];
    n1 = {2'h0, f[27:18]} + 12'h001;
    chk({28'h0, brake_align_prop_exp}, {28'h0, f[3:0]});
    chk({26'h0, brake_align_int_exp}, {26'h0, f[9:4]});
    chk({28'h0, reverse_openloop_speed_thresh}, f[12:10] + 32'h1);
    chk({26'h0, reverse_d_current_ref}, f[17:13] + 32'h1);
    chk({20'h0, tach_gain_num}, (f[30:28] == 3'h0) ? n1 : n1 << 1);
    chk({28'h0, tach_gain_den}, (f[30:28] == 3'h0) ? 32'h1 :
        f[30:28] + 32'h1);
    chk({28'h0, pole_pair_count}, f[30:28] + 32'h1);
    chk({31'h0, no_motor_detect_en}, {31'h0, f[31]});
    chk({20'h0, stator_inductance}, {20'h0, l[11:0]});
    chk({27'h0, stator_inductance_frac},
        {27'h0, 5'h05 + {l[15], l[15:12]}});
    chk({26'h0, rampup_d_current_ref}, r[25:21] + 32'h1);
    chk({27'h0, drive_d_current_ref},
        {27'h0, 5'h00 - {1'b0, r[29:26]}});
    chk({27'h0, d_axis_prop_exp}, {27'h0, g[4:0]});
    chk({26'h0, d_axis_int_exp}, {26'h0, g[10:5]});
    chk({27'h0, q_axis_prop_exp}, {27'h0, g[15:11]});
  endtask

  task automatic rd_chk(input logic [11:0] ra);
    logic [63:0] d;
    u_focpb_host.rd32(ra, 1, d);
    chk(d[31:0], mem_m.exists(ra) ? mem_m[ra] : 32'h0);
  endtask

  // upper half of the inductance word is not stored
  task automatic wr_chk(input logic [6:0] dev, input logic [11:0] ra,
                        input logic [31:0] d);
    logic ok;
    u_focpb_host.wr32(dev, ra, {32'h0, d}, 1, ok);
    chk({31'h0, ok}, {31'h0, dev == DEV});
    if (dev == DEV && mem_m.exists(ra))
      mem_m[ra] = (ra == `FOCPB_OFS_LS) ? {16'h0, d[15:0]} : d;
    chk_outs();
    rd_chk(ra);
  endtask

  // two words per transfer; the target steps the address between them
  task automatic burst_chk(input logic [63:0] w);
    logic ok;
    logic [63:0] d;
    u_focpb_host.wr32(DEV, `FOCPB_OFS_FGP_SH, w, 2, ok);
    mem_m[`FOCPB_OFS_FGP_SH] = w[63:32];
    mem_m[`FOCPB_OFS_DREF_SH] = w[31:0];
    chk({31'h0, ok}, 32'h1);
    chk_outs();
    u_focpb_host.rd32(`FOCPB_OFS_FGP_SH, 2, d);
    chk(d[63:32], w[63:32]);
    chk(d[31:0], w[31:0]);
  endtask

  initial begin
    rst_b = 1'b0;
    foreach (ofs[i]) mem_m[ofs[i]] = 32'h0;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk_outs();
    foreach (ofs[i]) rd_chk(ofs[i]);
    $display("test reset done");
    for (int p = 0; p < 8; p++)
      wr_chk(DEV, `FOCPB_OFS_FGP_SH,
        {p[0], p[2:0], {10{p[0]}}, {5{!p[0]}}, p[2:0], p[1], 5'h0A, p[2],
        3'h3});
    $display("test pole pairs done");
    wr_chk(DEV, `FOCPB_OFS_LS, 32'hFFFF8ABC);
    wr_chk(DEV, `FOCPB_OFS_LS, 32'h00007001);
    $display("test inductance done");
    wr_chk(DEV, `FOCPB_OFS_DREF_SH, 32'h3FE00000);
    wr_chk(DEV, `FOCPB_OFS_DREF_SH, 32'h04200000);
    $display("test d references done");
    wr_chk(DEV, `FOCPB_OFS_PIG_SH, 32'h00007FF0);
    wr_chk(DEV, `FOCPB_OFS_PIG_SH, 32'hFFFF840F);
    $display("test pi gains done");
    for (int i = 4; i < 7; i++)
      wr_chk(DEV, ofs[i], 32'hA5A55A5A ^ i);
    $display("test nvm copies done");
    wr_chk(DEV, 12'h400, 32'h12345678);
    wr_chk(7'h2A, `FOCPB_OFS_FGP_SH, 32'hFFFFFFFF);
    $display("test refusals done");
    burst_chk(64'h5000000003E00000);
    $display("test bursts done");
    complete_run();
  end

  // longest legal run is about 83000 cycles
  initial begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
